// File: hw/nvmpb_ctrl.v
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "nvmpb_regs.vh"
module nvmpb_ctrl #(
	parameter FLASH_AW = 13,
	parameter EE_AW = 7,
	parameter USER_AW = 5,
	parameter PAGE_AW = 6,
	parameter EE_PAGE_AW = 5
) (
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire ce_in,
	input wire [3:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	input wire [15:0] mem_addr_in,
	input wire [7:0] mem_wdata_in,
	input wire mem_wr_in,
	input wire mem_rd_in,
	output reg [7:0] mem_rdata_out,
	output reg mem_wait_out,
	input wire [15:0] exec_pc_in,
	input wire [7:0] loader_size_fuse_in,
	input wire [7:0] program_end_fuse_in,
	input wire sleep_in,
	input wire dbg_active_in,
	input wire chip_locked_in,
	output reg busy_out
);
	localparam FLASH_BYTES = 1 << FLASH_AW;
	localparam EE_BYTES = 1 << EE_AW;
	localparam USER_BYTES = 1 << USER_AW;
	localparam PAGE_BYTES = 1 << PAGE_AW;
	localparam EE_PAGE_BYTES = 1 << EE_PAGE_AW;
	localparam integer OP_LAST_INT = `NVMPB_OP_CYCLES - 1;
	localparam [15:0] OP_LAST = OP_LAST_INT[15:0];

	// ----------------------------------------
	// decoding functions
	// ----------------------------------------
	function [1:0] nvmpb_section;
		input [15:0] off;
		input [7:0] loader_fuse;
		input [7:0] prog_fuse;
		begin
			if (off < ({8'h00, loader_fuse} << `NVMPB_FUSE_UNIT_SHIFT))
				nvmpb_section = `NVMPB_SEC_LOADER;
			else if (off < ({8'h00, prog_fuse} << `NVMPB_FUSE_UNIT_SHIFT))
				nvmpb_section = `NVMPB_SEC_PROGRAM;
			else
				nvmpb_section = `NVMPB_SEC_DATA;
		end
	endfunction

	function [1:0] nvmpb_region;
		input [15:0] a;
		begin
			if (a[15])
				nvmpb_region = `NVMPB_RGN_FLASH;
			else if ((a >> EE_AW) == (`NVMPB_EEPROM_BASE >> EE_AW))
				nvmpb_region = `NVMPB_RGN_EEPROM;
			else if ((a >> USER_AW) == (`NVMPB_USER_BASE >> USER_AW))
				nvmpb_region = `NVMPB_RGN_USER;
			else
				nvmpb_region = `NVMPB_RGN_NONE;
		end
	endfunction

	function nvmpb_may_write;
		input [1:0] src;
		input [1:0] rgn;
		input [1:0] tsec;
		input prog_lock;
		input locked;
		begin
			nvmpb_may_write = 1'b0;
			if (src == `NVMPB_SRC_DEBUG)
				nvmpb_may_write = !locked || (rgn == `NVMPB_RGN_USER);
			else if (src == `NVMPB_SEC_DATA)
				nvmpb_may_write = 1'b0;
			else if (rgn == `NVMPB_RGN_EEPROM || rgn == `NVMPB_RGN_USER)
				nvmpb_may_write = 1'b1;
			else if (rgn == `NVMPB_RGN_FLASH) begin
				if (tsec == `NVMPB_SEC_LOADER)
					nvmpb_may_write = 1'b0;
				else if (tsec == `NVMPB_SEC_DATA)
					nvmpb_may_write = 1'b1;
				else
					nvmpb_may_write = (src == `NVMPB_SEC_LOADER) && !prog_lock;
			end
		end
	endfunction

	// ----------------------------------------
	// pin synchronisers and page buffer
	// ----------------------------------------
	wire [1:0] pins_sync;
	wire dbg_active = pins_sync[0];
	wire chip_locked = pins_sync[1];

	nvmpb_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.async_in({chip_locked_in, dbg_active_in}),
		.sync_out(pins_sync)
	);

	reg busy;
	reg [15:0] op_cnt;
	reg [2:0] op_cmd;
	reg [1:0] op_rgn;
	reg [1:0] tgt_rgn;
	reg [FLASH_AW-1:0] tgt_base;
	reg [EE_AW-EE_PAGE_AW-1:0] tgt_ee_page;
	reg tgt_valid;
	reg [1:0] lock;
	reg [7:0] loader_fuse;
	reg [7:0] prog_fuse;
	reg fuse_loaded;
	reg sleep_d;

	wire op_done = busy && (op_cnt == 16'h0000);
	wire [1:0] src_sec = dbg_active ? `NVMPB_SRC_DEBUG :
		nvmpb_section(exec_pc_in, loader_fuse, prog_fuse);
	wire [1:0] st_rgn = nvmpb_region(mem_addr_in);
	wire [15:0] st_flash_off = {{(16-FLASH_AW){1'b0}}, mem_addr_in[FLASH_AW-1:0]};
	wire [1:0] st_sec = nvmpb_section(st_flash_off, loader_fuse, prog_fuse);
	wire [1:0] tgt_sec = nvmpb_section({{(16-FLASH_AW){1'b0}}, tgt_base},
		loader_fuse, prog_fuse);
	// no store is taken while busy: the buffer is cleared when the op ends
	wire st_ok = mem_wr_in && !busy && (st_rgn != `NVMPB_RGN_NONE) &&
		nvmpb_may_write(src_sec, st_rgn, st_sec, lock[`NVMPB_LOCK_PROG_BIT],
		chip_locked);
	wire cmd_wr = reg_wr_in && (reg_addr_in == `NVMPB_REG_CMD) && !busy;
	wire [2:0] cmd = reg_wdata_in[2:0];
	wire cmd_page = (cmd == `NVMPB_CMD_PAGE_WRITE) || (cmd == `NVMPB_CMD_PAGE_ERASE) ||
		(cmd == `NVMPB_CMD_ERASE_WRITE);
	wire cmd_ok_page = cmd_wr && cmd_page && tgt_valid &&
		nvmpb_may_write(src_sec, tgt_rgn, tgt_sec, lock[`NVMPB_LOCK_PROG_BIT],
		chip_locked);
	wire cmd_ok_chip = cmd_wr && (cmd == `NVMPB_CMD_CHIP_ERASE) &&
		(src_sec == `NVMPB_SRC_DEBUG);
	wire cmd_clear = cmd_wr && (cmd == `NVMPB_CMD_BUF_CLEAR);
	// sleep entry and wake both show as a change of the sleep level
	wire sleep_edge = sleep_in ^ sleep_d;
	wire buf_clr = op_done || cmd_clear || sleep_edge;
	wire [PAGE_AW-1:0] buf_idx = (st_rgn == `NVMPB_RGN_FLASH) ?
		mem_addr_in[PAGE_AW-1:0] :
		{{(PAGE_AW-EE_PAGE_AW){1'b0}}, mem_addr_in[EE_PAGE_AW-1:0]};
	wire [PAGE_BYTES*8-1:0] buf_data;
	wire [PAGE_BYTES-1:0] buf_mark;

	nvmpb_page_buf #(
		.AW(PAGE_AW),
		.DEPTH(PAGE_BYTES)
	) u_buf (
		.clk_sys_in(clk_sys_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.clr_in(buf_clr),
		.wr_in(st_ok),
		.idx_in(buf_idx),
		.data_in(mem_wdata_in),
		.data_out(buf_data),
		.mark_out(buf_mark)
	);

	// ----------------------------------------
	// control state
	// ----------------------------------------
	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy <= 1'b0;
			busy_out <= 1'b0;
			mem_wait_out <= 1'b0;
			op_cnt <= 16'h0000;
			op_cmd <= `NVMPB_CMD_NONE;
			op_rgn <= `NVMPB_RGN_NONE;
			tgt_rgn <= `NVMPB_RGN_NONE;
			tgt_base <= {FLASH_AW{1'b0}};
			tgt_ee_page <= {(EE_AW-EE_PAGE_AW){1'b0}};
			tgt_valid <= 1'b0;
			lock <= `NVMPB_LOCK_RESET;
			loader_fuse <= 8'h00;
			prog_fuse <= 8'h00;
			fuse_loaded <= 1'b0;
			sleep_d <= 1'b0;
		end else if (ce_in) begin
			sleep_d <= sleep_in;
			// fuses are caught after reset release, never in the reset branch
			if (!fuse_loaded) begin
				loader_fuse <= loader_size_fuse_in;
				prog_fuse <= program_end_fuse_in;
				fuse_loaded <= 1'b1;
			end
			// locks only ever set; reset is the only way out
			if (reg_wr_in && (reg_addr_in == `NVMPB_REG_LOCK))
				lock <= lock | reg_wdata_in[1:0];
			// a store in the clearing cycle still lands: set wins
			if (buf_clr)
				tgt_valid <= 1'b0;
			if (st_ok) begin
				tgt_rgn <= st_rgn;
				tgt_valid <= 1'b1;
				if (st_rgn == `NVMPB_RGN_FLASH)
					tgt_base <= {mem_addr_in[FLASH_AW-1:PAGE_AW], {PAGE_AW{1'b0}}};
				else
					tgt_base <= {FLASH_AW{1'b0}};
				if (st_rgn == `NVMPB_RGN_EEPROM)
					tgt_ee_page <= mem_addr_in[EE_AW-1:EE_PAGE_AW];
			end
			if (cmd_ok_page || cmd_ok_chip) begin
				busy <= 1'b1;
				busy_out <= 1'b1;
				mem_wait_out <= 1'b1;
				op_cnt <= OP_LAST;
				op_cmd <= cmd;
				op_rgn <= cmd_ok_chip ? `NVMPB_RGN_NONE : tgt_rgn;
			end else if (op_done) begin
				busy <= 1'b0;
				busy_out <= 1'b0;
				mem_wait_out <= 1'b0;
				op_cmd <= `NVMPB_CMD_NONE;
			end else if (busy) begin
				op_cnt <= op_cnt - 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// nonvolatile arrays
	// ----------------------------------------
	reg [7:0] flash_mem [0:FLASH_BYTES-1];
	reg [7:0] ee_mem [0:EE_BYTES-1];
	reg [7:0] user_mem [0:USER_BYTES-1];
	integer i;

	// arrays keep their contents through reset, as the cells would
	always @(posedge clk_sys_in) begin
		if (ce_in && op_done) begin
			if (op_cmd == `NVMPB_CMD_CHIP_ERASE) begin
				for (i = 0; i < FLASH_BYTES; i = i + 1)
					flash_mem[i] <= 8'hff;
				for (i = 0; i < EE_BYTES; i = i + 1)
					ee_mem[i] <= 8'hff;
			end else if (op_rgn == `NVMPB_RGN_FLASH) begin
				// program only clears bits, so an unerased page ends up garbled
				for (i = 0; i < PAGE_BYTES; i = i + 1) begin
					case (op_cmd)
						`NVMPB_CMD_PAGE_ERASE: begin
							flash_mem[tgt_base | i[FLASH_AW-1:0]] <= 8'hff;
						end
						`NVMPB_CMD_ERASE_WRITE: begin
							flash_mem[tgt_base | i[FLASH_AW-1:0]] <= buf_data[i*8 +: 8];
						end
						default: begin
							flash_mem[tgt_base | i[FLASH_AW-1:0]] <=
								flash_mem[tgt_base | i[FLASH_AW-1:0]] & buf_data[i*8 +: 8];
						end
					endcase
				end
			end else if (op_rgn == `NVMPB_RGN_EEPROM) begin
				for (i = 0; i < EE_PAGE_BYTES; i = i + 1) begin
					if (buf_mark[i]) begin
						case (op_cmd)
							`NVMPB_CMD_PAGE_ERASE: begin
								ee_mem[{tgt_ee_page, i[EE_PAGE_AW-1:0]}] <= 8'hff;
							end
							`NVMPB_CMD_ERASE_WRITE: begin
								ee_mem[{tgt_ee_page, i[EE_PAGE_AW-1:0]}] <= buf_data[i*8 +: 8];
							end
							default: begin
								ee_mem[{tgt_ee_page, i[EE_PAGE_AW-1:0]}] <=
									ee_mem[{tgt_ee_page, i[EE_PAGE_AW-1:0]}] & buf_data[i*8 +: 8];
							end
						endcase
					end
				end
			end else if (op_rgn == `NVMPB_RGN_USER) begin
				for (i = 0; i < USER_BYTES; i = i + 1) begin
					if (buf_mark[i]) begin
						case (op_cmd)
							`NVMPB_CMD_PAGE_ERASE: begin
								user_mem[i] <= 8'hff;
							end
							`NVMPB_CMD_ERASE_WRITE: begin
								user_mem[i] <= buf_data[i*8 +: 8];
							end
							default: begin
								user_mem[i] <= user_mem[i] & buf_data[i*8 +: 8];
							end
						endcase
					end
				end
			end
		end
	end

	// ----------------------------------------
	// read paths
	// ----------------------------------------
	wire loader_hidden = lock[`NVMPB_LOCK_LOADER_BIT] && (st_sec == `NVMPB_SEC_LOADER);

	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mem_rdata_out <= 8'h00;
		end else if (ce_in && mem_rd_in && !busy) begin
			case (st_rgn)
				`NVMPB_RGN_FLASH: begin
					if (loader_hidden)
						mem_rdata_out <= 8'h00;
					else
						mem_rdata_out <= flash_mem[mem_addr_in[FLASH_AW-1:0]];
				end
				`NVMPB_RGN_EEPROM: mem_rdata_out <= ee_mem[mem_addr_in[EE_AW-1:0]];
				`NVMPB_RGN_USER: mem_rdata_out <= user_mem[mem_addr_in[USER_AW-1:0]];
				default: mem_rdata_out <= 8'h00;
			endcase
		end
	end

	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (ce_in) begin
			if (reg_rd_in) begin
				case (reg_addr_in)
					`NVMPB_REG_CMD: reg_rdata_out <= {5'h00, op_cmd};
					`NVMPB_REG_LOCK: reg_rdata_out <= {6'h00, lock};
					`NVMPB_REG_STATUS: reg_rdata_out <= {4'h0, tgt_rgn, tgt_valid, busy};
					`NVMPB_REG_LOADER_FUSE: reg_rdata_out <= loader_fuse;
					`NVMPB_REG_PROGRAM_FUSE: reg_rdata_out <= prog_fuse;
					default: reg_rdata_out <= 8'h00;
				endcase
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end
endmodule

// File: hw/nvmpb_page_buf.v
`timescale 1ns/1ps
module nvmpb_page_buf #(
	parameter AW = 6,
	parameter DEPTH = 64
) (
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire ce_in,
	input wire clr_in,
	input wire wr_in,
	input wire [AW-1:0] idx_in,
	input wire [7:0] data_in,
	output wire [DEPTH*8-1:0] data_out,
	output wire [DEPTH-1:0] mark_out
);
	// ----------------------------------------
	// one byte lane per buffer position
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : lane
			reg [7:0] byte_q;
			reg mark_q;
			wire hit = wr_in && (idx_in == g);
			always @(posedge clk_sys_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					byte_q <= 8'hff;
					mark_q <= 1'b0;
				end else if (ce_in) begin
					if (clr_in) begin
						// a store in the clearing cycle still lands: set wins
						byte_q <= hit ? data_in : 8'hff;
						mark_q <= hit;
					end else if (hit) begin
						byte_q <= byte_q & data_in;
						mark_q <= 1'b1;
					end
				end
			end
			assign data_out[g*8 +: 8] = byte_q;
			assign mark_out[g] = mark_q;
		end
	endgenerate
endmodule

// File: hw/nvmpb_regs.vh
`ifndef NVMPB_REGS_VH
`define NVMPB_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define NVMPB_REG_CMD 4'h0
`define NVMPB_REG_LOCK 4'h1
`define NVMPB_REG_STATUS 4'h2
`define NVMPB_REG_LOADER_FUSE 4'h3
`define NVMPB_REG_PROGRAM_FUSE 4'h4

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define NVMPB_LOCK_PROG_BIT 0
`define NVMPB_LOCK_LOADER_BIT 1
`define NVMPB_LOCK_RESET 2'h0
`define NVMPB_STATUS_BUSY_BIT 0
`define NVMPB_STATUS_VALID_BIT 1
`define NVMPB_CMD_RESET 3'h0

// ----------------------------------------
// commands
// ----------------------------------------
`define NVMPB_CMD_NONE 3'h0
`define NVMPB_CMD_PAGE_WRITE 3'h1
`define NVMPB_CMD_PAGE_ERASE 3'h2
`define NVMPB_CMD_ERASE_WRITE 3'h3
`define NVMPB_CMD_BUF_CLEAR 3'h4
`define NVMPB_CMD_CHIP_ERASE 3'h5

// ----------------------------------------
// sections, sources and regions
// ----------------------------------------
`define NVMPB_SEC_LOADER 2'h0
`define NVMPB_SEC_PROGRAM 2'h1
`define NVMPB_SEC_DATA 2'h2
`define NVMPB_SRC_DEBUG 2'h3
`define NVMPB_RGN_NONE 2'h0
`define NVMPB_RGN_FLASH 2'h1
`define NVMPB_RGN_EEPROM 2'h2
`define NVMPB_RGN_USER 2'h3

// ----------------------------------------
// memory map and fuse unit
// ----------------------------------------
`define NVMPB_EEPROM_BASE 16'h1400
`define NVMPB_USER_BASE 16'h1300
`define NVMPB_FUSE_UNIT_SHIFT 8

// ----------------------------------------
// timing
// ----------------------------------------
`define NVMPB_CLK_PERIOD_NS 40
`define NVMPB_OP_TIME_NS 4000
`define NVMPB_OP_CYCLES ((`NVMPB_OP_TIME_NS + `NVMPB_CLK_PERIOD_NS - 1) / `NVMPB_CLK_PERIOD_NS)

`endif

// File: hw/nvmpb_sync.v
`timescale 1ns/1ps
module nvmpb_sync #(
	parameter WIDTH = 2
) (
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire ce_in,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	reg [WIDTH-1:0] meta;

	always @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else if (ce_in) begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// File: verification/nvmpb_cpu_model.sv
`timescale 1ns/1ps
module nvmpb_cpu_model (
	input wire logic clk_sys_in,
	input wire logic mem_wait_in,
	input wire logic [7:0] mem_rdata_in,
	output logic [15:0] mem_addr_out,
	output logic [7:0] mem_wdata_out,
	output logic mem_wr_out,
	output logic mem_rd_out,
	output logic [15:0] exec_pc_out
);
	initial begin
		mem_addr_out = 16'h0000;
		mem_wdata_out = 8'h00;
		mem_wr_out = 1'b0;
		mem_rd_out = 1'b0;
		exec_pc_out = 16'h0000;
	end

	// ----------------------------------------
	// one load or store, held while the wait is up
	// ----------------------------------------
	task automatic access(input logic wr, input logic [15:0] pc, input logic [15:0] addr,
		input logic [7:0] wdata, output logic [7:0] rdata);
		logic w;
		@(posedge clk_sys_in);
		exec_pc_out <= pc;
		mem_addr_out <= addr;
		mem_wdata_out <= wdata;
		mem_wr_out <= wr;
		mem_rd_out <= !wr;
		w = 1'b1;
		while (w) begin
			@(negedge clk_sys_in);
			w = mem_wait_in;
			@(posedge clk_sys_in);
		end
		mem_wr_out <= 1'b0;
		mem_rd_out <= 1'b0;
		// released lines show no stale value
		mem_addr_out <= ~addr;
		mem_wdata_out <= ~wdata;
		@(negedge clk_sys_in);
		rdata = mem_rdata_in;
	endtask
endmodule

// File: verification/nvmpb_ctrl_props.sv
`timescale 1ns/1ps
`include "nvmpb_regs.vh"
module nvmpb_ctrl_props (
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire ce_in,
	input wire [3:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_rdata_out,
	input wire [15:0] mem_addr_in,
	input wire [7:0] mem_wdata_in,
	input wire mem_wr_in,
	input wire mem_rd_in,
	input wire [7:0] mem_rdata_out,
	input wire mem_wait_out,
	input wire [15:0] exec_pc_in,
	input wire [7:0] loader_size_fuse_in,
	input wire [7:0] program_end_fuse_in,
	input wire sleep_in,
	input wire dbg_active_in,
	input wire chip_locked_in,
	input wire busy_out
);
	localparam int OP_LEN = `NVMPB_OP_CYCLES;
	logic [7:0] busy_len;
	logic ldr_lock;

	// ----------------------------------------
	// helper state
	// ----------------------------------------
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_len <= 8'h00;
			ldr_lock <= 1'b0;
		end else begin
			busy_len <= busy_out ? busy_len + 8'h01 : 8'h00;
			if (reg_wr_in && reg_addr_in == `NVMPB_REG_LOCK &&
				reg_wdata_in[`NVMPB_LOCK_LOADER_BIT]) begin
				ldr_lock <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);

	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_cmd_write;
		reg_wr_in && reg_addr_in == `NVMPB_REG_CMD;
	endsequence
	sequence s_busy_run;
		busy_out [*8];
	endsequence
	property p_wait_is_busy;
		mem_wait_out == busy_out;
	endproperty
	property p_busy_cause;
		$rose(busy_out) |-> $past(reg_wr_in && reg_addr_in == `NVMPB_REG_CMD);
	endproperty
	property p_busy_hold;
		s_cmd_write ##1 $rose(busy_out) |-> s_busy_run;
	endproperty
	property p_busy_len;
		$fell(busy_out) |-> busy_len == OP_LEN;
	endproperty
	property p_load_held;
		busy_out && mem_rd_in |=> $stable(mem_rdata_out);
	endproperty
	property p_status_busy;
		reg_rd_in && reg_addr_in == `NVMPB_REG_STATUS |=>
			reg_rdata_out[`NVMPB_STATUS_BUSY_BIT] == $past(busy_out);
	endproperty
	property p_fuse_read;
		reg_rd_in && reg_addr_in == `NVMPB_REG_LOADER_FUSE |=>
			reg_rdata_out == $past(loader_size_fuse_in);
	endproperty
	property p_clear_idle;
		s_cmd_write ##0 (reg_wdata_in[2:0] == `NVMPB_CMD_BUF_CLEAR && !busy_out) |=> !busy_out;
	endproperty
	property p_loader_hidden;
		mem_rd_in && !busy_out && ldr_lock && !dbg_active_in && mem_addr_in[15] &&
			{3'h0, mem_addr_in[12:8]} < loader_size_fuse_in |=> mem_rdata_out == 8'h00;
	endproperty

	a_wait_is_busy:
		assert property (p_wait_is_busy) else $error("bus wait differs from busy");
	a_busy_cause:
		assert property (p_busy_cause) else $error("busy rose without a command");
	a_busy_hold:
		assert property (p_busy_hold) else $error("busy dropped early");
	a_busy_len:
		assert property (p_busy_len) else $error("busy length wrong");
	a_load_held:
		assert property (p_load_held) else $error("load taken while busy");
	a_status_busy:
		assert property (p_status_busy) else $error("status busy bit wrong");
	a_fuse_read:
		assert property (p_fuse_read) else $error("loader fuse readback wrong");
	a_clear_idle:
		assert property (p_clear_idle) else $error("buffer clear started busy");
	a_loader_hidden:
		assert property (p_loader_hidden) else $error("locked loader read leaked");
endmodule

bind nvmpb_ctrl nvmpb_ctrl_props props_u (.clk_sys_in, .reset_n_in, .ce_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mem_addr_in, .mem_wdata_in,
	.mem_wr_in, .mem_rd_in, .mem_rdata_out, .mem_wait_out, .exec_pc_in, .loader_size_fuse_in,
	.program_end_fuse_in, .sleep_in, .dbg_active_in, .chip_locked_in, .busy_out);

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "nvmpb_regs.vh"
module testbench;
	localparam logic [15:0] PL = 16'h0010;
	localparam logic [15:0] PP = 16'h0410;
	localparam logic [15:0] PD = 16'h0910;
	localparam logic [2:0] EW = `NVMPB_CMD_ERASE_WRITE;
	logic clk_sys_in, reset_n_in, ce_in, reg_wr_in, reg_rd_in, mem_wr_in, mem_rd_in;
	logic mem_wait_out, busy_out, sleep_in, dbg_active_in, chip_locked_in;
	logic [3:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out, mem_wdata_in, mem_rdata_out, d, b;
	logic [7:0] loader_size_fuse_in, program_end_fuse_in;
	logic [15:0] mem_addr_in, exec_pc_in;
	logic [15:0] tp [5] = '{PD, PD, PP, PL, PL};
	logic [15:0] ta [5] = '{16'h8840, 16'h1420, 16'h8440, 16'h8480, 16'h8040};
	logic [4:0] tok = 5'b01000;
	int fail_count = 0;
	int check_count = 0;
	time t0;

	nvmpb_ctrl dut_u (.clk_sys_in, .reset_n_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .mem_addr_in, .mem_wdata_in, .mem_wr_in, .mem_rd_in,
		.mem_rdata_out, .mem_wait_out, .exec_pc_in, .loader_size_fuse_in, .program_end_fuse_in,
		.sleep_in, .dbg_active_in, .chip_locked_in, .busy_out);
	nvmpb_cpu_model cpu_u (.clk_sys_in, .mem_wait_in(mem_wait_out), .mem_rdata_in(mem_rdata_out),
		.mem_addr_out(mem_addr_in), .mem_wdata_out(mem_wdata_in), .mem_wr_out(mem_wr_in),
		.mem_rd_out(mem_rd_in), .exec_pc_out(exec_pc_in));

	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rw(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rget(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_sys_in);
		v = reg_rdata_out;
	endtask
	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] e);
		logic [7:0] v;
		rget(a, v);
		check(what, v, e);
	endtask
	task automatic st(input logic [15:0] pc, input logic [15:0] a, input logic [7:0] v);
		logic [7:0] x;
		cpu_u.access(1'b1, pc, a, v, x);
	endtask
	task automatic lchk(input string what, input logic [15:0] pc, input logic [15:0] a,
		input logic [7:0] e);
		cpu_u.access(1'b0, pc, a, 8'h00, d);
		check(what, d, e);
	endtask
	task automatic wait_idle();
		int i;
		i = 0;
		@(negedge clk_sys_in);
		while (busy_out !== 1'b0 && i < 300) begin
			@(negedge clk_sys_in);
			i++;
		end
	endtask
	// busy is read back through status while the page or chip operation runs
	// target fields of status still stand during the op, so only the busy bit is judged
	task automatic commit(input logic [2:0] c, input logic bz);
		logic [7:0] v;
		rw(`NVMPB_REG_CMD, {5'h0, c});
		@(negedge clk_sys_in);
		check("busy pin", {7'h0, busy_out}, {7'h0, bz});
		rget(`NVMPB_REG_STATUS, v);
		check("status busy", {7'h0, v[`NVMPB_STATUS_BUSY_BIT]}, {7'h0, bz});
		rchk("running cmd", `NVMPB_REG_CMD, bz ? {5'h0, c} : 8'h00);
		wait_idle();
	endtask
	task automatic pins(input logic dbg, input logic lk);
		@(posedge clk_sys_in);
		dbg_active_in <= dbg;
		chip_locked_in <= lk;
		repeat (3) @(posedge clk_sys_in);
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		fail_count++;
		tally_and_finish();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		reset_n_in = 1'b0;
		ce_in = 1'b1;
		reg_addr_in = 4'h0;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		sleep_in = 1'b0;
		dbg_active_in = 1'b0;
		chip_locked_in = 1'b0;
		loader_size_fuse_in = 8'h04;
		program_end_fuse_in = 8'h08;
		repeat (16) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rchk("loader fuse", `NVMPB_REG_LOADER_FUSE, 8'h04);
		rchk("program fuse", `NVMPB_REG_PROGRAM_FUSE, 8'h08);
		rchk("lock reset", `NVMPB_REG_LOCK, 8'h00);
		rchk("unmapped", 4'hf, 8'h00);
		st(PL, 16'h1305, 8'h5a);
		commit(EW, 1'b1);
		pins(1'b1, 1'b0);
		commit(`NVMPB_CMD_CHIP_ERASE, 1'b1);
		pins(1'b0, 1'b0);
		lchk("user kept", PL, 16'h1305, 8'h5a);
		lchk("flash erased", PL, 16'h8805, 8'hff);
		st(PP, 16'h8805, 8'hf0);
		st(PP, 16'h8805, 8'h3c);
		rchk("status flash", `NVMPB_REG_STATUS, 8'h06);
		rw(`NVMPB_REG_CMD, {5'h0, `NVMPB_CMD_PAGE_WRITE});
		t0 = $time;
		lchk("and merge", PP, 16'h8805, 8'h30);
		check("stalled", {7'h0, ($time - t0) >= `NVMPB_OP_TIME_NS}, 8'h01);
		lchk("neighbour", PP, 16'h8804, 8'hff);
		st(PP, 16'h8806, 8'h0f);
		commit(EW, 1'b1);
		lchk("op clears buffer", PP, 16'h8805, 8'hff);
		lchk("erase write", PP, 16'h8806, 8'h0f);
		st(PP, 16'h8806, 8'hff);
		commit(`NVMPB_CMD_PAGE_ERASE, 1'b1);
		lchk("page erase", PP, 16'h8806, 8'hff);
		st(PP, 16'h8810, 8'h00);
		commit(`NVMPB_CMD_BUF_CLEAR, 1'b0);
		st(PP, 16'h8811, 8'haa);
		commit(EW, 1'b1);
		lchk("clear command", PP, 16'h8810, 8'hff);
		lchk("after clear", PP, 16'h8811, 8'haa);
		st(PP, 16'h8812, 8'h00);
		@(posedge clk_sys_in);
		sleep_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		sleep_in <= 1'b0;
		st(PP, 16'h8813, 8'h55);
		commit(EW, 1'b1);
		lchk("sleep clears", PP, 16'h8812, 8'hff);
		cpu_u.access(1'b0, PL, 16'h1441, 8'h00, b);
		st(PL, 16'h1440, 8'h12);
		rchk("status eeprom", `NVMPB_REG_STATUS, 8'h0a);
		commit(EW, 1'b1);
		lchk("marked byte", PL, 16'h1440, 8'h12);
		lchk("unmarked byte", PL, 16'h1441, b);
		for (int i = 0; i < 5; i++) begin
			cpu_u.access(1'b0, PL, ta[i], 8'h00, b);
			st(tp[i], ta[i], 8'h11);
			rw(`NVMPB_REG_CMD, {5'h0, EW});
			wait_idle();
			lchk("section", PL, ta[i], tok[i] ? 8'h11 : b);
		end
		@(posedge clk_sys_in);
		ce_in <= 1'b0;
		rw(`NVMPB_REG_LOCK, 8'h01);
		ce_in <= 1'b1;
		rchk("frozen lock", `NVMPB_REG_LOCK, 8'h00);
		rw(`NVMPB_REG_LOCK, 8'h01);
		rw(`NVMPB_REG_LOCK, 8'h00);
		rchk("lock kept", `NVMPB_REG_LOCK, 8'h01);
		st(PL, 16'h84c0, 8'h22);
		rw(`NVMPB_REG_CMD, {5'h0, EW});
		wait_idle();
		lchk("program locked", PL, 16'h84c0, 8'hff);
		lchk("loader open", PP, 16'h8000, 8'hff);
		rw(`NVMPB_REG_LOCK, 8'h02);
		rchk("both locks", `NVMPB_REG_LOCK, 8'h03);
		lchk("loader hidden", PP, 16'h8000, 8'h00);
		lchk("loader fetch hidden", PL, 16'h8001, 8'h00);
		pins(1'b1, 1'b1);
		st(16'h0000, 16'h1306, 8'h77);
		commit(EW, 1'b1);
		pins(1'b0, 1'b0);
		lchk("user via debug", PP, 16'h1306, 8'h77);
		@(posedge clk_sys_in);
		reset_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rchk("lock cleared", `NVMPB_REG_LOCK, 8'h00);
		tally_and_finish();
	end
endmodule
